// ===== rtl/pts_consts.svh
// Named offsets, field positions, reset values and counts for the period timer.
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// Register indexes; the byte address of a register is four times its index.
`define PTS_IDX_FLAGS        8'h0c
`define PTS_IDX_FLAG_CLEAR   8'h0d
`define PTS_IDX_COUNT        8'h11
`define PTS_IDX_CONTROL      8'h12
`define PTS_IDX_ENABLES      8'h8c
`define PTS_IDX_PERIOD       8'h92

// Field positions.
`define PTS_FLAG_BIT         1
`define PTS_RUN_BIT          2
`define PTS_PRE_LO           0
`define PTS_PRE_HI           1
`define PTS_POST_LO          3
`define PTS_POST_HI          6

// Reset values.
`define PTS_COUNT_RST        8'h00
`define PTS_PERIOD_RST       8'hff
`define PTS_CONTROL_RST      7'h00
`define PTS_ENABLES_RST      8'h00

// Prescale selections and the last prescaler state for each ratio.
`define PTS_PRE_SEL_DIV1     2'h0
`define PTS_PRE_SEL_DIV4     2'h1
`define PTS_PRE_LAST_DIV1    4'h0
`define PTS_PRE_LAST_DIV4    4'h3
`define PTS_PRE_LAST_DIV16   4'hf

// Oscillator phases per instruction cycle, as the last phase number.
`define PTS_PHASE_LAST       2'h3

`endif

// ===== rtl/pts_pkg.sv
// Types shared by the period timer: bus request carrier, bus phase and module state.
package pts_pkg;

	typedef enum logic {
		PTS_BUS_IDLE = 1'b0,
		PTS_BUS_DONE = 1'b1
	} pts_bus_e;

	typedef struct packed {
		logic [9:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} pts_avm_req_s;

	typedef struct packed {
		pts_bus_e    bus;
		logic [31:0] readdata;
		logic [7:0]  count;
		logic [7:0]  period;
		logic [6:0]  control;
		logic [7:0]  enables;
		logic        flag;
		logic [1:0]  phase;
		logic [3:0]  pre;
		logic [3:0]  post;
		logic        match;
	} pts_state_s;

endpackage : pts_pkg

// ===== rtl/pts_timer.sv
// Period timer with prescaler, postscaler, interrupt flag and Avalon-MM register slave.
`timescale 1ns/1ps
//
// What this block does
// [RQ1] The count advances on the instruction clock, a quarter of MCLK, divided by 1, 4 or 16.
// [RQ2] Control bits 1:0 pick the prescale: 00 is 1, 01 is 4, 1x is 16.
// [RQ3] The 8-bit count climbs from zero and, once equal to the period, goes to zero on the next increment.
// [RQ4] The period register comes out of reset as all ones.
// [RQ5] The count is zero after every reset.
// [RQ6] Period matches go through a 4-bit postscaler dividing by 1 to 16 before reaching the flag.
// [RQ7] Control bits 6:3 plus one give the postscale ratio.
// [RQ8] Each postscaler event sets bit 1 of the flag register, which holds until software clears it.
// [RQ9] Counting happens only while control bit 2 is set.
// [RQ10] Writes to the count or control register, and reset, clear the prescaler and postscaler.
// [RQ11] A control write leaves the count as it was.
// [RQ12] The raw match pulse, before the postscaler, goes out to the serial port.
// [RQ13] Count value and match pulse go out to the capture/compare units as their PWM time base.
// [RQ14] Software may read and write the period and count registers at any time.
// [RQ15] The interrupt output is high while the match flag and its enable bit are both set.
`include "pts_consts.svh"

module pts_timer
	import pts_pkg::*;
(
	// Clock and reset.
	input  wire logic        MCLK,
	input  wire logic        RST,
	// Avalon-MM slave, byte addressed.
	input  wire logic [9:0]  ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [3:0]  BYTEENABLE,
	input  wire logic [31:0] WRITEDATA,
	output logic      [31:0] READDATA,
	output logic             WAITREQUEST,
	// Interrupt.
	output logic             IRQ,
	// Time base for the serial port and capture/compare units.
	output logic             MATCH_PULSE,
	output logic      [7:0]  COUNT_VALUE
);

	////////////////////////////////////////////////////////////////////////////
	// Request decode.

	pts_avm_req_s req;
	pts_state_s   st;
	pts_state_s   next_st;
	logic [7:0]   index;
	logic         accept;
	logic         lane0;
	logic         wr_count;
	logic         wr_control;
	logic         wr_period;
	logic         wr_enables;
	logic         wr_clear;
	logic         phase_end;
	logic [3:0]   pre_last;
	logic         inc;
	logic         post_event;

	// Bundle the bus pins so the decode reads as one request.
	assign req   = '{address: ADDRESS, read: READ, write: WRITE, byteenable: BYTEENABLE, writedata: WRITEDATA};
	assign index = req.address[9:2];
	assign lane0 = req.byteenable[0];

	// A request is answered on the cycle after it is first seen, so waitrequest drops once.
	assign WAITREQUEST = (req.read | req.write) & (st.bus == PTS_BUS_IDLE);
	assign accept      = (req.read | req.write) & (st.bus == PTS_BUS_DONE);

	// Write strobes act only at the accepting edge and only with the low byte lane enabled.
	assign wr_count   = accept & req.write & lane0 & (index == `PTS_IDX_COUNT);
	assign wr_control = accept & req.write & lane0 & (index == `PTS_IDX_CONTROL);
	assign wr_period  = accept & req.write & lane0 & (index == `PTS_IDX_PERIOD);
	assign wr_enables = accept & req.write & lane0 & (index == `PTS_IDX_ENABLES);
	assign wr_clear   = accept & req.write & lane0 & (index == `PTS_IDX_FLAG_CLEAR);

	////////////////////////////////////////////////////////////////////////////
	// Time base.

	// Last prescaler state for the selected ratio; both 1x codes mean divide by 16.
	always_comb begin
		case (st.control[`PTS_PRE_HI:`PTS_PRE_LO])
			`PTS_PRE_SEL_DIV1: pre_last = `PTS_PRE_LAST_DIV1; // [RQ2]
			`PTS_PRE_SEL_DIV4: pre_last = `PTS_PRE_LAST_DIV4; // [RQ2]
			default:           pre_last = `PTS_PRE_LAST_DIV16; // [RQ2]
		endcase
	end

	// A control write suppresses the increment so that the count cannot move under it.
	assign phase_end  = (st.phase == `PTS_PHASE_LAST); // [RQ1]
	assign inc        = st.control[`PTS_RUN_BIT] & phase_end & (st.pre == pre_last) & ~wr_count & ~wr_control; // [RQ9]
	assign post_event = inc & (st.count == st.period) &
		(st.post == st.control[`PTS_POST_HI:`PTS_POST_LO]); // [RQ6] [RQ7]

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	// All state moves here; writes win over counting, and a flag set wins over its clear.
	always_comb begin
		next_st       = st;
		next_st.match = 1'b0;
		next_st.phase = st.phase + 2'h1; // [RQ1]
		// Bus phase and read data, ready at the accepting edge.
		case (st.bus)
			PTS_BUS_IDLE: begin
				if (req.read | req.write) begin
					next_st.bus = PTS_BUS_DONE;
				end
			end
			PTS_BUS_DONE: begin
				next_st.bus = PTS_BUS_IDLE;
			end
			default: begin
				next_st.bus = PTS_BUS_IDLE;
			end
		endcase
		next_st.readdata = 32'h0000_0000;
		if (req.read & (st.bus == PTS_BUS_IDLE)) begin
			case (index)
				`PTS_IDX_FLAGS:   next_st.readdata[`PTS_FLAG_BIT] = st.flag;
				`PTS_IDX_COUNT:   next_st.readdata[7:0] = st.count; // [RQ14]
				`PTS_IDX_CONTROL: next_st.readdata[6:0] = st.control;
				`PTS_IDX_ENABLES: next_st.readdata[7:0] = st.enables;
				`PTS_IDX_PERIOD:  next_st.readdata[7:0] = st.period; // [RQ14]
				default:          next_st.readdata = 32'h0000_0000;
			endcase
		end
		// Prescaler runs on instruction-cycle boundaries while the timer is on.
		if (st.control[`PTS_RUN_BIT] & phase_end) begin // [RQ9]
			next_st.pre = (st.pre == pre_last) ? 4'h0 : st.pre + 4'h1; // [RQ1]
		end
		// Count and match.
		if (inc) begin
			if (st.count == st.period) begin
				next_st.count = `PTS_COUNT_RST; // [RQ3]
				next_st.match = 1'b1; // [RQ12] [RQ13]
				next_st.post  = post_event ? 4'h0 : st.post + 4'h1; // [RQ6]
			end else begin
				next_st.count = st.count + 8'h01; // [RQ3]
			end
		end
		// Register writes.
		if (wr_count) begin
			next_st.count = req.writedata[7:0]; // [RQ14]
		end
		if (wr_count | wr_control) begin
			next_st.pre  = 4'h0; // [RQ10]
			next_st.post = 4'h0; // [RQ10]
		end
		if (wr_control) begin
			next_st.control = req.writedata[6:0]; // [RQ11]
		end
		if (wr_period) begin
			next_st.period = req.writedata[7:0]; // [RQ14]
		end
		if (wr_enables) begin
			next_st.enables = req.writedata[7:0];
		end
		if (wr_clear & req.writedata[`PTS_FLAG_BIT]) begin
			next_st.flag = 1'b0;
		end
		if (post_event) begin
			next_st.flag = 1'b1; // [RQ8]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	// Every reset clears count, scalers and flag and reloads the period.
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st          <= '0;
			st.bus      <= PTS_BUS_IDLE;
			st.count    <= `PTS_COUNT_RST; // [RQ5]
			st.period   <= `PTS_PERIOD_RST; // [RQ4]
			st.control  <= `PTS_CONTROL_RST;
			st.enables  <= `PTS_ENABLES_RST;
			st.pre      <= 4'h0; // [RQ10]
			st.post     <= 4'h0; // [RQ10]
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	// The count and match are registered so the consumers see clean levels.
	assign READDATA    = st.readdata;
	assign COUNT_VALUE = st.count; // [RQ13]
	assign MATCH_PULSE = st.match; // [RQ12]
	assign IRQ         = st.flag & st.enables[`PTS_FLAG_BIT]; // [RQ15]

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	period_reset_a: assert property ($fell(RST) |-> st.period == `PTS_PERIOD_RST) // [RQ4]
		else $error("period not all ones after reset");
	count_reset_a: assert property ($fell(RST) |-> st.count == `PTS_COUNT_RST) // [RQ5]
		else $error("count not zero after reset");
	count_wrap_a: assert property (inc && st.count == st.period |=> st.count == 8'h00 && MATCH_PULSE) // [RQ3]
		else $error("count did not wrap on period match");
	count_step_a: assert property (inc && st.count != st.period |=> st.count == $past(st.count) + 8'h01) // [RQ3]
		else $error("count did not advance by one");
	stopped_hold_a: assert property (!st.control[`PTS_RUN_BIT] && !wr_count |=> $stable(st.count)) // [RQ9]
		else $error("count moved while stopped");
	control_keep_a: assert property (wr_control |=> st.count == $past(st.count)) // [RQ11]
		else $error("control write altered count");
	scaler_clear_a: assert property (wr_count || wr_control |=> st.pre == 4'h0 && st.post == 4'h0) // [RQ10]
		else $error("scalers not cleared by write");
	div1_rate_a: assert property (inc && st.control[1:0] == 2'h0 && st.control[`PTS_RUN_BIT]
		##1 !wr_count && !wr_control [*4] |-> inc) // [RQ1]
		else $error("divide by one rate wrong");
	// A control write may pick a faster ratio and restart the prescaler, so it ends the attempt.
	div4_gap_a: assert property (disable iff (RST || wr_control)
		inc && st.control[1] == 1'b0 && st.control[0] == 1'b1 |=> !inc [*8]) // [RQ2]
		else $error("divide by four increments too soon");
	flag_set_a: assert property (post_event |=> st.flag) // [RQ8]
		else $error("postscaler event did not set flag");
	post_div_a: assert property (MATCH_PULSE && st.control[6:3] == 4'h1 && $past(st.post) == 4'h0 |-> !st.flag
		|| $past(st.flag)) // [RQ7]
		else $error("postscale by two set flag on first match");
	irq_level_a: assert property ($rose(st.flag) && st.enables[1] |-> IRQ ##1 (IRQ || !st.flag)) // [RQ15]
		else $error("interrupt not raised with flag and enable");
	bus_answer_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
		else $error("bus answer not given in one cycle");

endmodule : pts_timer

// ===== test/pts_timer_bench.sv
// Self-checking bench for the period timer registers, time base and interrupt.
`timescale 1ns/1ps
`include "pts_consts.svh"

module pts_timer_bench import pts_pkg::*;;

	logic        MCLK, RST, READ, WRITE, WAITREQUEST, IRQ, MATCH_PULSE;
	logic [9:0]  ADDRESS;
	logic [3:0]  BYTEENABLE;
	logic [31:0] WRITEDATA, READDATA, rd, hold;
	logic [7:0]  COUNT_VALUE;
	int          n_fail, check_count, n;
	int          div[4] = '{1, 4, 16, 16};

	pts_timer u_pts_timer (.MCLK(MCLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
		.BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
		.IRQ(IRQ), .MATCH_PULSE(MATCH_PULSE), .COUNT_VALUE(COUNT_VALUE));

	////////////////////////////////////////////////////////////////////////////////
	// The clock runs at 50 MHz.
	initial begin
		MCLK = 1'b0;
		forever #10 MCLK = ~MCLK;
	end

	task automatic complete_run();
		if (n_fail == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask : check

	// One Avalon transfer; the request holds until the rising edge where waitrequest is sampled low.
	task automatic bus(logic wr_en, logic [7:0] idx, logic [7:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge MCLK);
		ADDRESS   <= {idx, 2'h0};
		READ      <= !wr_en;
		WRITE     <= wr_en;
		WRITEDATA <= {24'h0, d};
		do begin
			@(posedge MCLK);
			k++;
		end while (WAITREQUEST !== 1'b0 && k < 50);
		if (k >= 50) begin
			n_fail++;
			complete_run();
		end
		q = READDATA;
		READ  <= 1'b0;
		WRITE <= 1'b0;
	endtask : bus

	task automatic wr(logic [7:0] idx, logic [7:0] d);
		bus(1'b1, idx, d, rd);
	endtask : wr

	task automatic rdc(string what, logic [7:0] idx, logic [7:0] exp);
		bus(1'b0, idx, 8'h00, rd);
		check(what, rd, {24'h0, exp});
	endtask : rdc

	// Counts cycles up to the next match pulse; a missing pulse ends the run.
	task automatic wait_pulse(output int k);
		k = 0;
		do begin
			@(negedge MCLK);
			k++;
		end while (MATCH_PULSE !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			n_fail++;
			complete_run();
		end
	endtask : wait_pulse

	// Counts matches until the interrupt rises; one extra cycle covers a flag that leads the pulse.
	task automatic post_run(logic [3:0] field, logic mid);
		int p, k;
		p = 0;
		k = 0;
		wr(`PTS_IDX_CONTROL, 8'h00);
		wr(`PTS_IDX_COUNT, 8'h00);
		wr(`PTS_IDX_FLAG_CLEAR, 8'h02);
		wr(`PTS_IDX_CONTROL, {1'b0, field, 3'h4});
		if (mid) begin
			wait_pulse(k);
			wr(`PTS_IDX_COUNT, 8'h00);
		end
		k = 0;
		while (IRQ !== 1'b1 && k < 3000) begin
			@(negedge MCLK);
			k++;
			if (MATCH_PULSE === 1'b1) p++;
		end
		if (k >= 3000) begin
			n_fail++;
			complete_run();
		end
		@(negedge MCLK);
		if (MATCH_PULSE === 1'b1) p++;
		check("postscale matches", p, field + 1);
	endtask : post_run

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset values, prescale ratios, postscale ratios, stop, flag handling.
	initial begin
		{RST, READ, WRITE, ADDRESS, WRITEDATA} = {1'b1, 44'h0};
		BYTEENABLE = 4'hf;
		n_fail = 0;
		check_count = 0;
		repeat (5) @(posedge MCLK);
		RST <= 1'b0;
		rdc("count reset", `PTS_IDX_COUNT, 8'h00);
		rdc("period reset", `PTS_IDX_PERIOD, 8'hff);
		rdc("control reset", `PTS_IDX_CONTROL, 8'h00);
		rdc("flags reset", `PTS_IDX_FLAGS, 8'h00);
		rdc("unmapped", 8'h50, 8'h00);
		wr(`PTS_IDX_PERIOD, 8'h02);
		rdc("period", `PTS_IDX_PERIOD, 8'h02);
		for (int s = 0; s < 4; s++) begin
			wr(`PTS_IDX_CONTROL, 8'h04 | s[7:0]);
			wait_pulse(n);
			check("count at match", {24'h0, COUNT_VALUE}, 0);
			wait_pulse(n);
			check("match interval", n, 12 * div[s]);
		end
		wr(`PTS_IDX_PERIOD, 8'h01);
		wr(`PTS_IDX_ENABLES, 8'h02);
		post_run(4'h0, 1'b0);
		post_run(4'h2, 1'b0);
		post_run(4'h1, 1'b1);
		post_run(4'hf, 1'b0);
		// Stopped timer must hold its count; the latched flag survives a write to its read-only home.
		wr(`PTS_IDX_CONTROL, 8'h00);
		bus(1'b0, `PTS_IDX_COUNT, 8'h00, hold);
		repeat (100) @(negedge MCLK);
		rdc("stopped count", `PTS_IDX_COUNT, hold[7:0]);
		wr(`PTS_IDX_FLAGS, 8'h00);
		rdc("flag latched", `PTS_IDX_FLAGS, 8'h02);
		wr(`PTS_IDX_ENABLES, 8'h00);
		repeat (2) @(negedge MCLK);
		check("irq masked", {31'h0, IRQ}, 0);
		wr(`PTS_IDX_ENABLES, 8'h02);
		repeat (2) @(negedge MCLK);
		check("irq enabled", {31'h0, IRQ}, 1);
		wr(`PTS_IDX_FLAG_CLEAR, 8'h02);
		rdc("flag cleared", `PTS_IDX_FLAGS, 8'h00);
		check("irq cleared", {31'h0, IRQ}, 0);
		wr(`PTS_IDX_COUNT, 8'h05);
		wr(`PTS_IDX_CONTROL, 8'hfb);
		rdc("control bits", `PTS_IDX_CONTROL, 8'h7b);
		rdc("count kept", `PTS_IDX_COUNT, 8'h05);
		complete_run();
	end

endmodule : pts_timer_bench
